/* File: shared/wdt_pkg.sv */
// Constants, register map and field layouts of the 16-bit timer and watchdog.
// Assumes a single 10 MHz reference clock and an APB register slave.
//
// How it works
// - Reload value and current count are 16-bit unsigned, and writes to the count are ignored.
// - Any write to the clear register drops the timer interrupt in normal mode and restarts the timeout in watchdog mode; an interrupt set in that cycle stays.
// - The read/write reload register holds the load value and resets to 0x3BF8.
// - Reading the current count returns the live counter, which resets to 0x3BF8.
// - Control bit 8 set counts up and clear counts down.
// - Control bit 7 set lets the counter advance and clear holds it.
// - Control bit 6 set reloads on overflow and clear lets the counter wrap through its full range.
// - Control bit 5 set selects watchdog operation and clear keeps normal timer operation.
// - Control bits 3:2 divide the 32.768 kHz source by 1, 16 or 256, and 11 is reserved.
// - In watchdog mode reaching zero raises the interrupt when bit 1 is set and requests a reset when it is clear.
// - With bit 0 set the counter stops during peripheral power-down and with it clear it keeps counting.
// - The counter reloads from the reload register on overflow when bit 6 is set, and at once on a clear register write.
// - In watchdog mode the counter decrements from the reload value down to zero.
// - Once watchdog mode is on, reload and control ignore writes until power-on reset, and other resets leave it counting.
// - The counter halts while a debugger holds the core and resumes when it lets go.

package wdt_pkg;

  // ---------------------------------------------------------------------------
  // Clocks
  // ---------------------------------------------------------------------------
  localparam int REF_CLK_HZ = 10_000_000;
  localparam int SRC_CLK_HZ = 32_768;
  localparam int ACC_W      = 24;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(SRC_CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(REF_CLK_HZ);

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_RELOAD = 32'hFFFF_0360;
  localparam logic [31:0] ADDR_COUNT  = 32'hFFFF_0364;
  localparam logic [31:0] ADDR_CTRL   = 32'hFFFF_0368;
  localparam logic [31:0] ADDR_CLEAR  = 32'hFFFF_036C;

  localparam logic [15:0] RELOAD_RST = 16'h3BF8;
  localparam logic [15:0] COUNT_RST  = 16'h3BF8;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h01EF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [15:0] RD_PAD     = 16'h0000;
  localparam logic [31:0] RD_NONE    = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------------------
  localparam int PRE_W = 8;
  localparam logic [3:0]       DIV16_LAST  = 4'hF;
  localparam logic [PRE_W-1:0] DIV256_LAST = 8'hFF;
  localparam logic [PRE_W-1:0] PRE_ONE     = 8'h01;

  typedef enum logic [1:0] {
    PRE_DIV1   = 2'b00,
    PRE_DIV16  = 2'b01,
    PRE_DIV256 = 2'b10,
    PRE_RSVD   = 2'b11
  } prescale_e;

  // ---------------------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic       count_direction;
    logic       count_enable;
    logic       periodic_select;
    logic       watchdog_mode_enable;
    logic       rsvd_4;
    prescale_e  prescale_select;
    logic       expiry_irq_select;
    logic       stop_in_powerdown;
  } ctrl_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

/* File: core/osc_tick_gen.sv */
// Low-power oscillator tick made from the reference clock.
// Assumes the reference runs at REF_CLK_HZ; ticks average SRC_CLK_HZ.
`timescale 1ns/1ps

module osc_tick_gen
  import wdt_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  output logic      o_src_tick
);

  // ---------------------------------------------------------------------------
  // Phase accumulator
  // ---------------------------------------------------------------------------
  // Fractional stepping; jitter is one reference period, fine for a watchdog
  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] nxt_acc;
  logic             tick_ff;

  always_comb begin
    nxt_acc = acc_ff + ACC_STEP;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      acc_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (nxt_acc >= ACC_MOD) begin
      acc_ff  <= nxt_acc - ACC_MOD;
      tick_ff <= 1'b1;
    end else begin
      acc_ff  <= nxt_acc;
      tick_ff <= 1'b0;
    end
  end

  assign o_src_tick = tick_ff;

endmodule

/* File: core/prescale_div.sv */
// Divider of the source tick by 1, 16 or 256.
// Assumes i_src_tick is a one-cycle pulse; o_tick is a registered pulse.
`timescale 1ns/1ps

module prescale_div
  import wdt_pkg::*;
(
  input  wire logic      i_ref_clk,
  input  wire logic      i_rstn,
  input  wire logic      i_src_tick,
  input  wire prescale_e i_sel,
  output logic           o_tick
);

  // ---------------------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------------------
  logic [PRE_W-1:0] div_ff;
  logic             tick_ff;
  logic             nxt_tick;

  always_comb begin
    case (i_sel)
      PRE_DIV1:   nxt_tick = i_src_tick;
      PRE_DIV16:  nxt_tick = i_src_tick && (div_ff[3:0] == DIV16_LAST);
      PRE_DIV256: nxt_tick = i_src_tick && (div_ff == DIV256_LAST);
      default:    nxt_tick = 1'b0; // Reserved code holds the count
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      div_ff <= '0;
    end else if (i_src_tick) begin
      div_ff <= div_ff + PRE_ONE;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;

endmodule

/* File: core/timer_watchdog_16bit.sv */
// 16-bit up/down timer with watchdog mode, registers on APB.
// Assumes i_rstn is the power-on reset and i_warm_rstn any other reset.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps

module timer_watchdog_16bit
  import wdt_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_warm_rstn,
  input  wire logic        i_powerdown,
  input  wire logic        i_debug_halt,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_irq,
  output logic             o_rst_req
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  apb_req_s    req;
  ctrl_s       ctrl_ff;
  ctrl_s       wr_ctrl;
  logic [15:0] reload_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        irq_ff;
  logic        rst_req_ff;

  logic        setup;
  logic        access;
  logic        hit_reload;
  logic        hit_count;
  logic        hit_ctrl;
  logic        hit_clear;
  logic        mapped;
  logic        wr_reload;
  logic        wr_ctrl_en;
  logic        wr_clear;
  logic        wd_mode;
  logic        warm_clr;

  logic        src_tick;
  logic        pre_tick;
  logic        run;
  logic        step;
  logic        overflow;
  logic        expire;
  logic        irq_set;
  logic        rst_set;

  // ---------------------------------------------------------------------------
  // Bus request bundle
  // ---------------------------------------------------------------------------
  always_comb begin
    req.psel    = i_psel;
    req.penable = i_penable;
    req.pwrite  = i_pwrite;
    req.paddr   = i_paddr;
    req.pwdata  = i_pwdata;
  end

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  assign setup      = req.psel && !req.penable;
  assign access     = req.psel && req.penable;
  assign mapped     = hit_reload || hit_count || hit_ctrl || hit_clear;

  // All 32 address bits compared, so no alias of a register answers
  always_comb begin
    hit_reload = 1'b0;
    hit_count  = 1'b0;
    hit_ctrl   = 1'b0;
    hit_clear  = 1'b0;
    case (req.paddr)
      ADDR_RELOAD: begin
        hit_reload = 1'b1;
      end
      ADDR_COUNT: begin
        hit_count = 1'b1;
      end
      ADDR_CTRL: begin
        hit_ctrl = 1'b1;
      end
      ADDR_CLEAR: begin
        hit_clear = 1'b1;
      end
      default: begin
        hit_reload = 1'b0;
      end
    endcase
  end

  assign wd_mode    = ctrl_ff.watchdog_mode_enable;

  // ---------------------------------------------------------------------------
  // Write strobes
  // ---------------------------------------------------------------------------
  // Protection also blocks software from leaving watchdog mode
  assign wr_reload  = access && req.pwrite && hit_reload && !wd_mode;
  assign wr_ctrl_en = access && req.pwrite && hit_ctrl && !wd_mode;
  assign wr_clear   = access && req.pwrite && hit_clear;

  // A warm reset is ignored entirely once the watchdog is armed
  assign warm_clr   = !i_warm_rstn && !wd_mode;

  // ---------------------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------------------
  // Zero wait states; read data is sampled at the setup edge
  assign o_pready  = 1'b1;
  assign o_pslverr = access && !mapped;

  always_comb begin
    nxt_prdata = RD_NONE;
    if (hit_reload) begin
      nxt_prdata = {RD_PAD, reload_ff};
    end else if (hit_count) begin
      nxt_prdata = {RD_PAD, count_ff};
    end else if (hit_ctrl) begin
      nxt_prdata = {RD_PAD, ctrl_ff};
    end else begin
      nxt_prdata = RD_NONE; // Clear register is write only
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      prdata_ff <= RD_NONE;
    end else if (setup && !req.pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign o_prdata = prdata_ff;

  // ---------------------------------------------------------------------------
  // Reload register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      reload_ff <= RELOAD_RST;
    end else if (warm_clr) begin
      reload_ff <= RELOAD_RST;
    end else if (wr_reload) begin
      reload_ff <= req.pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  // Reserved bits are not stored, so a careless write cannot set them
  assign wr_ctrl = ctrl_s'(req.pwdata[15:0] & CTRL_WMASK);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ctrl_ff <= ctrl_s'(CTRL_RST);
    end else if (warm_clr) begin
      ctrl_ff <= ctrl_s'(CTRL_RST);
    end else if (wr_ctrl_en) begin
      ctrl_ff <= wr_ctrl;
    end
  end

  // ---------------------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------------------
  osc_tick_gen u_osc_tick_gen (
    .i_ref_clk  (i_ref_clk),
    .i_rstn     (i_rstn),
    .o_src_tick (src_tick)
  );

  prescale_div u_prescale_div (
    .i_ref_clk  (i_ref_clk),
    .i_rstn     (i_rstn),
    .i_src_tick (src_tick),
    .i_sel      (ctrl_ff.prescale_select),
    .o_tick     (pre_tick)
  );

  // ---------------------------------------------------------------------------
  // Count gating
  // ---------------------------------------------------------------------------
  // Debug halt overrides all, so a breakpoint never trips the watchdog
  always_comb begin
    run = ctrl_ff.count_enable;
    if (i_powerdown && ctrl_ff.stop_in_powerdown) begin
      run = 1'b0;
    end
    if (i_debug_halt) begin
      run = 1'b0;
    end
  end

  assign step = pre_tick && run;

  // ---------------------------------------------------------------------------
  // Next count
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_count = count_ff;
    overflow  = 1'b0;
    expire    = 1'b0;
    if (wd_mode) begin
      // Direction bit has no say here
      if (count_ff == COUNT_ZERO) begin
        nxt_count = reload_ff;
      end else begin
        nxt_count = count_ff - COUNT_ONE;
        expire    = (count_ff == COUNT_ONE);
      end
    end else if (ctrl_ff.count_direction) begin
      if (count_ff == COUNT_MAX) begin
        overflow  = 1'b1;
        nxt_count = ctrl_ff.periodic_select ? reload_ff : COUNT_ZERO;
      end else begin
        nxt_count = count_ff + COUNT_ONE;
      end
    end else begin
      if (count_ff == COUNT_ZERO) begin
        overflow  = 1'b1;
        nxt_count = ctrl_ff.periodic_select ? reload_ff : COUNT_MAX;
      end else begin
        nxt_count = count_ff - COUNT_ONE;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  // Writes to the count address never reach this register
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      count_ff <= COUNT_RST;
    end else if (warm_clr) begin
      count_ff <= COUNT_RST;
    end else if (wr_clear) begin
      count_ff <= reload_ff;
    end else if (step) begin
      count_ff <= nxt_count;
    end
  end

  // ---------------------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------------------
  // Normal mode flags every overflow, watchdog mode only the step into zero
  always_comb begin
    irq_set = 1'b0;
    rst_set = 1'b0;
    if (step) begin
      if (!wd_mode) begin
        irq_set = overflow;
      end else if (expire) begin
        if (ctrl_ff.expiry_irq_select) begin
          irq_set = 1'b1;
        end else begin
          rst_set = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------------------

  // Set beats clear so an expiry racing a refresh is never lost
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      irq_ff <= 1'b0;
    end else if (warm_clr) begin
      irq_ff <= 1'b0;
    end else if (irq_set) begin
      irq_ff <= 1'b1;
    end else if (wr_clear) begin
      irq_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rst_req_ff <= 1'b0;
    end else begin
      rst_req_ff <= rst_set;
    end
  end

  assign o_irq     = irq_ff;
  assign o_rst_req = rst_req_ff;

endmodule

/* File: testbench/timer_watchdog_16bit_properties.sv */
// Port checker for the 16-bit timer and watchdog.
// Assumes APB with zero wait states; bound to the top module below.
`timescale 1ns/1ps

module wdt_checker
  import wdt_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rstn,
  input wire logic        i_warm_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic        o_irq,
  input wire logic        o_rst_req
);
  // ----
  // Helpers
  // ----
  logic hit;
  logic clr_wr;
  assign hit = i_paddr inside {ADDR_RELOAD, ADDR_COUNT, ADDR_CTRL, ADDR_CLEAR};
  assign clr_wr = i_psel && i_penable && i_pwrite && (i_paddr == ADDR_CLEAR);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_acc;
    i_psel && i_penable;
  endsequence
  sequence s_clr_rd;
    i_psel && !i_penable && !i_pwrite && (i_paddr == ADDR_CLEAR);
  endsequence

  // ----
  // Properties
  // ----
  a_err_unmapped: assert property (s_acc ##0 !hit |-> o_pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (s_acc ##0 hit |-> !o_pslverr)
    else $error("error on mapped access");
  a_err_only_access: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("error outside access phase");
  a_read_upper_zero: assert property (o_prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_clear_reads_zero: assert property (s_clr_rd |=> o_prdata == 32'h0000_0000)
    else $error("clear register read not zero");
  a_rst_req_pulse: assert property ($rose(o_rst_req) |=> !o_rst_req)
    else $error("reset request longer than one cycle");
  a_irq_sticky: assert property (o_irq && !clr_wr && i_warm_rstn |=> o_irq)
    else $error("interrupt dropped without clear");
  a_irq_drop_cause: assert property ($fell(o_irq) |-> $past(clr_wr) || !$past(i_warm_rstn))
    else $error("interrupt fell without cause");
  a_reset_quiet: assert property (disable iff (1'b0) !i_rstn |=> !o_irq && !o_rst_req)
    else $error("event output during reset");
endmodule

bind timer_watchdog_16bit wdt_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_warm_rstn(i_warm_rstn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .o_irq(o_irq), .o_rst_req(o_rst_req));

/* File: testbench/timer_watchdog_16bit_test.sv */
// Self-checking bench for the 16-bit timer and watchdog.
// Assumes the 10 MHz reference; one count step per source tick (~305 cycles).
`timescale 1ns/1ps

module timer_watchdog_16bit_test;
  import wdt_pkg::*;
  logic        clk = 0, rstn = 0, warm_rstn = 1, pd = 0, dh = 0;
  logic        psel = 0, pen = 0, pwr = 0, pready, pslverr, irq, rst_req;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd, a;
  logic        er;
  int          num_errors = 0, checked = 0, n, rst_cnt = 0;

  always #50 clk = ~clk;
  always @(posedge clk) if (rst_req === 1'b1) rst_cnt <= rst_cnt + 1;

  timer_watchdog_16bit dut (
    .i_ref_clk(clk), .i_rstn(rstn), .i_warm_rstn(warm_rstn), .i_powerdown(pd),
    .i_debug_halt(dh), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_irq(irq), .o_rst_req(rst_req));

  // ----
  // Shared tasks
  // ----
  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Never assume zero wait states: wait for pready at each edge
  task apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin num_errors++; report_and_stop; end
    rd = prdata;
    er = pslverr;
    psel <= 0; pen <= 0;
  endtask
  task wr(input logic [31:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task rdc(input string nm, input logic [31:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task wait_ev(input logic r);
    n = 0;
    while ((r ? rst_req : irq) !== 1'b1 && n < 3000) begin @(posedge clk); n++; end
    if (n >= 3000) begin num_errors++; report_and_stop; end
  endtask

  // ----
  // Scenarios
  // ----
  task t_reset_map;
    rdc("reload", ADDR_RELOAD, 32'h0000_3BF8);
    rdc("count", ADDR_COUNT, 32'h0000_3BF8);
    rdc("ctrl", ADDR_CTRL, 32'h0000_0000);
    rdc("clear", ADDR_CLEAR, 32'h0000_0000);
    apb(1'b0, 32'hFFFF_0370, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'b0, er});
  endtask
  task t_fields;
    wr(ADDR_CTRL, 32'hFFFF_FEDF);
    rdc("ctrl mask", ADDR_CTRL, 32'h0000_00CF);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 32'(k << 2));
      rdc("prescale", ADDR_CTRL, 32'(k << 2));
    end
  endtask
  task t_load;
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_RELOAD, 32'h0000_0003);
    wr(ADDR_CLEAR, 32'h0000_00A5);
    rdc("count load", ADDR_COUNT, 32'h0000_0003);
    wr(ADDR_COUNT, 32'h0000_1234);
    rdc("count ro", ADDR_COUNT, 32'h0000_0003);
  endtask
  task t_overflow;
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_CLEAR, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0080 | 32'(m << 6));
      wait_ev(1'b0);
      chk("irq set", 32'h0000_0001, {31'b0, irq});
      rdc("after ovf", ADDR_COUNT, m ? 32'h0000_0003 : 32'h0000_FFFF);
      wr(ADDR_CLEAR, 32'h0000_0000);
      @(negedge clk);
      chk("irq clr", 32'h0000_0000, {31'b0, irq});
    end
  endtask
  // Two reads 700 cycles apart span at least two source ticks
  task gate(input logic [31:0] c, input logic p, input logic d, input logic e);
    cyc(1);
    pd <= p;
    dh <= d;
    wr(ADDR_CTRL, c);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000);
    a = rd;
    cyc(700);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000);
    chk("moved", {31'b0, e}, {31'b0, rd !== a});
    pd <= 0;
    dh <= 0;
  endtask
  // Up from 3 never wraps; divide by 16 steps every ~4883 cycles, so 1 or 2 in 8000
  task t_rate;
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_CLEAR, 32'h0000_0000);
    gate(32'h0000_0180, 1'b0, 1'b0, 1'b1);
    chk("up count", 32'h0000_0001, {31'b0, rd > 32'h0000_0003});
    wr(ADDR_CTRL, 32'h0000_0184);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000);
    a = rd;
    cyc(8000);
    apb(1'b0, ADDR_COUNT, 32'h0000_0000);
    chk("div16 steps", 32'h0000_0001, {31'b0, (rd - a) inside {[1:2]}});
  endtask
  task t_wdog_irq;
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_RELOAD, 32'h0000_0002);
    wr(ADDR_CLEAR, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_00A2);
    wr(ADDR_RELOAD, 32'h0000_0005);
    rdc("locked reload", ADDR_RELOAD, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0000);
    rdc("locked ctrl", ADDR_CTRL, 32'h0000_00A2);
    warm_rstn <= 0;
    cyc(3);
    warm_rstn <= 1;
    rdc("warm ctrl", ADDR_CTRL, 32'h0000_00A2);
    a = 32'(rst_cnt);
    wait_ev(1'b0);
    chk("wd irq", 32'h0000_0001, {31'b0, irq});
    rdc("wd zero", ADDR_COUNT, 32'h0000_0000);
    chk("no rst", a, 32'(rst_cnt));
    wr(ADDR_CLEAR, 32'h0000_0000);
    rdc("refresh", ADDR_COUNT, 32'h0000_0002);
    chk("wd irq clr", 32'h0000_0000, {31'b0, irq});
    rstn <= 0;
    cyc(12);
    rstn <= 1;
    rdc("por ctrl", ADDR_CTRL, 32'h0000_0000);
  endtask
  task t_wdog_rst;
    wr(ADDR_RELOAD, 32'h0000_0002);
    wr(ADDR_CLEAR, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_01A0);
    wait_ev(1'b1);
    @(posedge clk);
    chk("rst pulse", 32'h0000_0000, {31'b0, rst_req});
    rdc("wd down", ADDR_COUNT, 32'h0000_0000);
    chk("no irq", 32'h0000_0000, {31'b0, irq});
  endtask

  initial begin
    cyc(12);
    rstn <= 1;
    t_reset_map;
    t_fields;
    t_load;
    t_overflow;
    gate(32'h0000_0000, 1'b0, 1'b0, 1'b0);
    gate(32'h0000_0080, 1'b0, 1'b1, 1'b0);
    gate(32'h0000_0081, 1'b1, 1'b0, 1'b0);
    gate(32'h0000_0080, 1'b1, 1'b0, 1'b1);
    gate(32'h0000_008C, 1'b0, 1'b0, 1'b0);
    t_rate;
    t_wdog_irq;
    t_wdog_rst;
    report_and_stop;
  end
endmodule
